// ---- design/synth_link_consts.svh ----
// What this block does
// - clamp bit clamps pump while off
// - linearity field nonzero enables linearity mode
// - bit 10 picks integer or fractional
// - bit 9 picks lock detector algorithm
// - host sets rate bit from detector frequency
// - bit 7 picks 10ns or 6ns window
// - bit 6 sets phase detector polarity
// - bit 5 shuts the device down
// - bit 4 floats the pump output
// - bit 3 holds both counters reset
// - bit 31 selects write or read
// - bits 2:0 address; aux unused zeroed
// - bit 21 disables reference input stage
// - bits 20:19 pick divider function
// - divider value 1..4095, zero never programmed
// - converter mode off or temperature sensor
// - trigger bit starts one conversion, only with temperature sensor mode
// - power flag reads 1 until read once
// - valid low while converting, result 9:3
// - upper word address 011, reset 00000043
`ifndef SYNTH_LINK_CONSTS_SVH
`define SYNTH_LINK_CONSTS_SVH

// ********************************************************************
// serial word layout
// ********************************************************************
`define WORD_W          32
`define BIT_READ        31
`define ADDR_HI         2
`define ADDR_LO         0
`define ADDR_UPPER      3'h3
`define ADDR_AUX        3'h4
`define ADDR_STATUS     3'h6

// ********************************************************************
// upper control word
// ********************************************************************
`define UPPER_RESET     32'h00000043
`define UPPER_UNUSED_HI 30
`define UPPER_UNUSED_LO 18
`define BIT_CLAMP       13
`define LIN_HI          12
`define LIN_LO          11
`define BIT_INTEGER     10
`define BIT_LOCK_FUNC   9
`define BIT_LOCK_RATE   8
`define BIT_LOCK_WIN    7
`define BIT_POLARITY    6
`define BIT_POWER_DOWN  5
`define BIT_HIGH_Z      4
`define BIT_CNT_CLEAR   3

// ********************************************************************
// auxiliary word
// ********************************************************************
`define AUX_RESET       32'h00000004
`define AUX_UNUSED_HI   30
`define AUX_UNUSED_LO   22
`define BIT_REF_OFF     21
`define DIVM_HI         20
`define DIVM_LO         19
`define DIVV_HI         18
`define DIVV_LO         7
`define CONVM_HI        6
`define CONVM_LO        4
`define BIT_TRIGGER     3
`define CONVM_TEMP      3'h1

// ********************************************************************
// status word
// ********************************************************************
`define STATUS_UNUSED_W 19
`define RESULT_W        7

// ********************************************************************
// serial clock timing, in system clocks per half period
// ********************************************************************
`define DEF_SCLK_HALF   4

`endif

// ---- design/synth_link_pkg.sv ----
package synth_link_pkg;

  typedef logic [31:0] serial_word_t;
  typedef logic [2:0]  reg_addr_t;

  // host sequencer states
  typedef enum logic [2:0] {
    H_IDLE,
    H_SHIFT_LOW,
    H_SHIFT_HIGH,
    H_LATCH,
    H_READ_LOW,
    H_READ_HIGH
  } host_state_t;

endpackage : synth_link_pkg

// ---- design/serial_link_if.sv ----
`timescale 1ns/1ps
// 3-wire serial port plus readback line, all push-pull
interface serial_link_if;
  logic sclk;   // serial clock, made by the host
  logic sdata;  // host to device data
  logic le;     // latch enable, rising edge commits word
  logic sdo;    // device readback data

  modport device_end (input sclk, input sdata, input le, output sdo);
  modport host_end   (output sclk, output sdata, output le, input sdo);
endinterface : serial_link_if

// ---- design/synth_regs_device.sv ----
`timescale 1ns/1ps
`include "synth_link_consts.svh"

module synth_regs_device
  import synth_link_pkg::*;
(
  input  wire logic         clock,               // system clock
  input  wire logic         sys_rst,             // synchronous reset, high
  serial_link_if.device_end link,                // serial port from host
  input  wire logic         conv_done,           // converter finished, pulse
  input  wire logic [6:0]   conv_result,         // converter sample
  output logic              pump_clamp_en,       // clamp pump while off
  output logic              linearity_en,        // pump linearity mode on
  output logic              integer_mode,        // 1 integer, 0 fractional
  output logic              lock_det_integer,    // integer-N lock detector
  output logic              lock_rate_fast,      // detector above 32MHz
  output logic              lock_window_narrow,  // 6ns window when 1
  output logic              detector_positive,   // positive pfd polarity
  output logic              power_down,          // device shutdown
  output logic              pump_high_z,         // pump output floated
  output logic              counters_held,       // ref and fb counters reset
  output logic              reference_stage_off, // reference stage disabled
  output logic [1:0]        aux_divider_mode,    // divider function
  output logic [11:0]       aux_divider_value,   // divide ratio
  output logic              converter_on,        // temperature sensor selected
  output logic              conversion_start     // one-cycle start pulse
);

  // ******************************************************************
  // link edge detection
  // ******************************************************************
  logic         sclk_prev_reg;
  logic         le_prev_reg;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         le_rise;

  // inputs are taken as synchronous, so only a one-deep history is kept
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sclk_prev_reg <= 1'b0;
      le_prev_reg   <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= link.sclk;
      le_prev_reg   <= link.le;
    end
  end

  assign sclk_rise = link.sclk & ~sclk_prev_reg;
  assign sclk_fall = ~link.sclk & sclk_prev_reg;
  assign le_rise   = link.le & ~le_prev_reg;

  // ******************************************************************
  // inbound shift register
  // ******************************************************************
  serial_word_t shift_in_reg;
  logic         word_is_read;
  reg_addr_t    word_addr;
  logic         wr_upper;
  logic         wr_aux;
  logic         rd_any;

  // msb first; readback clocks also land here but are never latched
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      shift_in_reg <= '0;
    else if (sclk_rise)
      shift_in_reg <= {shift_in_reg[`WORD_W-2:0], link.sdata};
  end

  assign word_is_read = shift_in_reg[`BIT_READ];
  assign word_addr    = shift_in_reg[`ADDR_HI:`ADDR_LO];
  assign wr_upper     = le_rise & ~word_is_read & (word_addr == `ADDR_UPPER);
  assign wr_aux       = le_rise & ~word_is_read & (word_addr == `ADDR_AUX);
  assign rd_any       = le_rise & word_is_read;

  // ******************************************************************
  // upper control word
  // ******************************************************************
  serial_word_t upper_reg;
  logic         linearity_reg;

  // the address field is forced so readback always names the register
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      upper_reg <= `UPPER_RESET;
    else if (wr_upper)
      upper_reg <= {1'b0, shift_in_reg[`BIT_READ-1:`ADDR_HI+1], `ADDR_UPPER};
  end

  // any nonzero linearity code turns the mode on
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      linearity_reg <= 1'b0;
    else if (wr_upper)
      linearity_reg <= |shift_in_reg[`LIN_HI:`LIN_LO];
  end

  // control outputs other than linearity_en are taken straight from the stored word
  assign pump_clamp_en      = upper_reg[`BIT_CLAMP];
  assign linearity_en       = linearity_reg;
  assign integer_mode       = upper_reg[`BIT_INTEGER];
  assign lock_det_integer   = upper_reg[`BIT_LOCK_FUNC];
  assign lock_rate_fast     = upper_reg[`BIT_LOCK_RATE];
  assign lock_window_narrow = upper_reg[`BIT_LOCK_WIN];
  assign detector_positive  = upper_reg[`BIT_POLARITY];
  assign power_down         = upper_reg[`BIT_POWER_DOWN];
  assign pump_high_z        = upper_reg[`BIT_HIGH_Z];
  assign counters_held      = upper_reg[`BIT_CNT_CLEAR];

  // ******************************************************************
  // auxiliary word
  // ******************************************************************
  serial_word_t aux_reg;
  logic         conv_on_reg;
  logic         start_req;

  // unused bits are stored as written; the host keeps them zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      aux_reg <= `AUX_RESET;
    else if (wr_aux)
      aux_reg <= {1'b0, shift_in_reg[`BIT_READ-1:`ADDR_HI+1], `ADDR_AUX};
  end

  // only the temperature sensor code powers the converter; others are idle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      conv_on_reg <= 1'b0;
    else if (wr_aux)
      conv_on_reg <= (shift_in_reg[`CONVM_HI:`CONVM_LO] == `CONVM_TEMP);
  end

  assign reference_stage_off = aux_reg[`BIT_REF_OFF];
  assign aux_divider_mode    = aux_reg[`DIVM_HI:`DIVM_LO];
  assign aux_divider_value   = aux_reg[`DIVV_HI:`DIVV_LO];
  assign converter_on        = conv_on_reg;

  // a start only counts when the written mode enables the converter
  assign start_req = wr_aux & shift_in_reg[`BIT_TRIGGER]
                     & (shift_in_reg[`CONVM_HI:`CONVM_LO] == `CONVM_TEMP);

  // ******************************************************************
  // converter handshake and result
  // ******************************************************************
  logic         conv_start_reg;
  logic         conv_busy_reg;
  logic         conv_valid_reg;
  logic [6:0]   conv_data_reg;

  // start pulse towards the converter
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      conv_start_reg <= 1'b0;
    else
      conv_start_reg <= start_req;
  end

  assign conversion_start = conv_start_reg;

  // a new start beats a done in the same cycle: the old sample is stale
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      conv_busy_reg  <= 1'b0;
      conv_valid_reg <= 1'b0;
    end
    else if (start_req)
    begin
      conv_busy_reg  <= 1'b1;
      conv_valid_reg <= 1'b0;
    end
    else if (conv_busy_reg && conv_done)
    begin
      conv_busy_reg  <= 1'b0;
      conv_valid_reg <= 1'b1;
    end
  end

  // result changes only on the done of a conversion that was started
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      conv_data_reg <= '0;
    else if (conv_busy_reg && conv_done && !start_req)
      conv_data_reg <= conv_result;
  end

  // ******************************************************************
  // power-on flag
  // ******************************************************************
  logic         por_flag_reg;

  // the read that clears it still returns the 1 from its snapshot
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      por_flag_reg <= 1'b1;
    else if (rd_any && word_addr == `ADDR_STATUS)
      por_flag_reg <= 1'b0;
  end

  // ******************************************************************
  // readback
  // ******************************************************************
  serial_word_t rd_word;
  serial_word_t shift_out_reg;

  // addresses outside this slice read back as zero
  always_comb
  begin
    case (word_addr)
      `ADDR_UPPER:  rd_word = upper_reg;
      `ADDR_AUX:    rd_word = aux_reg;
      `ADDR_STATUS: rd_word = {1'b1, {`STATUS_UNUSED_W{1'b0}}, por_flag_reg,
                               conv_valid_reg, conv_data_reg, `ADDR_STATUS};
      default:      rd_word = '0;
    endcase
  end

  // snapshot on the latch, then advance after each falling sclk so the
  // host can sample on its rising edge with SCLK_HALF-1 clocks of margin
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      shift_out_reg <= '0;
    else if (rd_any)
      shift_out_reg <= rd_word;
    else if (sclk_fall)
      shift_out_reg <= {shift_out_reg[`WORD_W-2:0], 1'b0};
  end

  assign link.sdo = shift_out_reg[`WORD_W-1];

endmodule : synth_regs_device

// ---- design/synth_regs_host.sv ----
`timescale 1ns/1ps
`include "synth_link_consts.svh"

module synth_regs_host
  import synth_link_pkg::*;
#(
  parameter int SCLK_HALF = `DEF_SCLK_HALF                  // clocks per sclk half, at least 2
)
(
  input  wire logic         clock,        // system clock
  input  wire logic         sys_rst,      // synchronous reset, high
  serial_link_if.host_end   link,         // serial port to device
  input  wire logic         req_valid,    // request offered
  input  wire logic         req_read,     // 1 read, 0 write
  input  wire logic [2:0]   req_addr,     // register address
  input  wire logic [31:0]  req_data,     // write payload, bits 30:3 used
  input  wire logic         pfd_fast,     // detector frequency above 32MHz
  output logic              req_ready,    // request can be taken
  output logic              req_refused,  // pulse, request rejected
  output logic              rsp_valid,    // pulse, readback word ready
  output logic [31:0]       rsp_data      // readback word
);

  // build the serial word, forcing unused fields and the rate bit
  function automatic serial_word_t build_word(input logic rd, input reg_addr_t a,
                                              input serial_word_t d, input logic fast);
    serial_word_t w;
    w = {rd, d[`BIT_READ-1:`ADDR_HI+1], a};
    if (a == `ADDR_UPPER)
    begin
      w[`UPPER_UNUSED_HI:`UPPER_UNUSED_LO] = '0;
      w[`BIT_LOCK_RATE] = fast;
    end
    if (a == `ADDR_AUX)
      w[`AUX_UNUSED_HI:`AUX_UNUSED_LO] = '0;
    return w;
  endfunction : build_word

  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

  host_state_t  state_reg;
  serial_word_t word_reg;
  serial_word_t rx_reg;
  logic [7:0]   half_reg;
  logic [4:0]   bit_reg;
  logic         read_reg;
  logic         sclk_reg;
  logic         sdata_reg;
  logic         le_reg;
  logic         ready_reg;
  logic         refused_reg;
  logic         rsp_valid_reg;
  serial_word_t rsp_reg;
  logic         half_done;
  logic         zero_div;

  assign half_done = (half_reg == '0);
  // a zero divide ratio is never sent to the device
  assign zero_div  = ~req_read & (req_addr == `ADDR_AUX)
                     & (req_data[`DIVV_HI:`DIVV_LO] == '0);

  // ******************************************************************
  // frame sequencer: 32 bits out, latch, then 32 bits back on reads
  // ******************************************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg     <= H_IDLE;
      word_reg      <= '0;
      rx_reg        <= '0;
      half_reg      <= '0;
      bit_reg       <= '0;
      read_reg      <= 1'b0;
      sclk_reg      <= 1'b0;
      sdata_reg     <= 1'b0;
      le_reg        <= 1'b0;
      ready_reg     <= 1'b1;
      refused_reg   <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_reg       <= '0;
    end
    else
    begin
      refused_reg   <= 1'b0;
      rsp_valid_reg <= 1'b0;
      half_reg      <= half_done ? HALF_LAST : half_reg - 8'h01;
      case (state_reg)
        H_IDLE:
        begin
          half_reg <= HALF_LAST;
          if (req_valid && zero_div)
            refused_reg <= 1'b1;
          else if (req_valid)
          begin
            word_reg  <= build_word(req_read, req_addr, req_data, pfd_fast);
            sdata_reg <= req_read;
            read_reg  <= req_read;
            bit_reg   <= 5'(`WORD_W - 1);
            ready_reg <= 1'b0;
            state_reg <= H_SHIFT_LOW;
          end
        end
        H_SHIFT_LOW:
          if (half_done)
          begin
            sclk_reg  <= 1'b1;
            state_reg <= H_SHIFT_HIGH;
          end
        H_SHIFT_HIGH:
          if (half_done)
          begin
            sclk_reg <= 1'b0;
            if (bit_reg == '0)
            begin
              le_reg    <= 1'b1;
              sdata_reg <= 1'b0;
              state_reg <= H_LATCH;
            end
            else
            begin
              word_reg  <= {word_reg[`WORD_W-2:0], 1'b0};
              sdata_reg <= word_reg[`WORD_W-2];
              bit_reg   <= bit_reg - 5'h01;
              state_reg <= H_SHIFT_LOW;
            end
          end
        H_LATCH:
          if (half_done)
          begin
            le_reg  <= 1'b0;
            bit_reg <= 5'(`WORD_W - 1);
            if (read_reg)
              state_reg <= H_READ_LOW;
            else
            begin
              ready_reg <= 1'b1;
              state_reg <= H_IDLE;
            end
          end
        H_READ_LOW:
          if (half_done)
          begin
            sclk_reg  <= 1'b1;
            rx_reg    <= {rx_reg[`WORD_W-2:0], link.sdo};
            state_reg <= H_READ_HIGH;
          end
        H_READ_HIGH:
          if (half_done)
          begin
            sclk_reg <= 1'b0;
            if (bit_reg == '0)
            begin
              rsp_reg       <= rx_reg;
              rsp_valid_reg <= 1'b1;
              ready_reg     <= 1'b1;
              state_reg     <= H_IDLE;
            end
            else
            begin
              bit_reg   <= bit_reg - 5'h01;
              state_reg <= H_READ_LOW;
            end
          end
        default:
          state_reg <= H_IDLE;
      endcase
    end
  end

  assign link.sclk   = sclk_reg;
  assign link.sdata  = sdata_reg;
  assign link.le     = le_reg;
  assign req_ready   = ready_reg;
  assign req_refused = refused_reg;
  assign rsp_valid   = rsp_valid_reg;
  assign rsp_data    = rsp_reg;

endmodule : synth_regs_host

// ---- sim/serial_link_sva.sv ----
`timescale 1ns/1ps
// ********************************************************************
// wire checks on the serial link
// ********************************************************************
module serial_link_sva (
  input wire logic clock,   // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic sclk,    // serial clock
  input wire logic sdata,   // host to device data
  input wire logic le,      // latch enable
  input wire logic sdo      // readback data
);
  logic       sclk_q;
  logic       le_q;
  logic [6:0] rise_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // edge history of the link lines
  always_ff @(posedge clock)
  begin
    sclk_q <= sclk;
    le_q   <= le;
  end
  // sclk rises since the last commit; a read frame adds 32 more
  always_ff @(posedge clock)
  begin
    if (sys_rst || (le && !le_q))
      rise_cnt <= '0;
    else if (sclk && !sclk_q)
      rise_cnt <= rise_cnt + 7'h01;
  end
  word_count_a:
    assert property ($rose(le) |-> rise_cnt == 7'h20 || rise_cnt == 7'h40) else $error("le without full word");
  latch_low_a:
    assert property ($rose(le) |-> !sdata && !sclk) else $error("le rose with sclk or sdata high");
  latch_width_a:
    assert property ($rose(le) |-> le [*2] ##1 !le) else $error("le width wrong");
  clk_high_a:
    assert property ($rose(sclk) |-> sclk [*2] ##1 !sclk) else $error("sclk high width wrong");
  clk_low_a:
    assert property ($fell(sclk) |-> !sclk [*2]) else $error("sclk low too short");
  data_hold_a:
    assert property (sclk && $past(sclk) |-> $stable(sdata)) else $error("sdata moved while sclk high");
  sdo_timing_a:
    assert property ($changed(sdo) |-> ($past(sclk, 2) && !$past(sclk)) || ($past(le) && !$past(le, 2)))
      else $error("sdo moved off schedule");
  clk_quiet_a:
    assert property (le |-> !sclk) else $error("sclk pulsed during le");
endmodule : serial_link_sva

// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb
  import synth_link_pkg::*;
;
  logic clock = 0, sys_rst = 1, req_valid = 0, req_read = 0, pfd_fast = 0, conv_done = 0;
  logic [2:0] req_addr = 3'h0;
  logic [31:0] req_data = 32'h0, rsp_data, got;
  logic [6:0] conv_result = 7'h00;
  logic req_ready, req_refused, rsp_valid, pump_clamp_en, linearity_en, integer_mode, lock_det_integer;
  logic lock_rate_fast, lock_window_narrow, detector_positive, power_down, pump_high_z, counters_held;
  logic reference_stage_off, converter_on, conversion_start;
  logic [1:0] aux_divider_mode;
  logic [11:0] aux_divider_value;
  int n_mismatch = 0, checks = 0, cyc = 0, n_start = 0, n_ref = 0;
  logic [31:0] up_pat [4] = '{32'hfffffff8, 32'h00000800, 32'h00001000, 32'h00000000};
  logic [31:0] ax_pat [4] = '{32'h7ffffff8, 32'h00080080, 32'h00140000, 32'h00000000};
  logic [31:0] ax_last;
  wire [9:0] uo = {pump_clamp_en, linearity_en, integer_mode, lock_det_integer, lock_rate_fast,
                   lock_window_narrow, detector_positive, power_down, pump_high_z, counters_held};
  wire [14:0] ao = {reference_stage_off, aux_divider_mode, aux_divider_value};
  serial_link_if serial_link_if_inst ();
  synth_regs_host #(.SCLK_HALF(2)) synth_regs_host_inst (.clock(clock), .sys_rst(sys_rst),
    .link(serial_link_if_inst), .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr),
    .req_data(req_data), .pfd_fast(pfd_fast), .req_ready(req_ready), .req_refused(req_refused),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  synth_regs_device synth_regs_device_inst (.clock(clock), .sys_rst(sys_rst), .link(serial_link_if_inst),
    .conv_done(conv_done), .conv_result(conv_result), .pump_clamp_en(pump_clamp_en),
    .linearity_en(linearity_en), .integer_mode(integer_mode), .lock_det_integer(lock_det_integer),
    .lock_rate_fast(lock_rate_fast), .lock_window_narrow(lock_window_narrow),
    .detector_positive(detector_positive), .power_down(power_down), .pump_high_z(pump_high_z),
    .counters_held(counters_held), .reference_stage_off(reference_stage_off),
    .aux_divider_mode(aux_divider_mode), .aux_divider_value(aux_divider_value),
    .converter_on(converter_on), .conversion_start(conversion_start));
  serial_link_sva serial_link_sva_inst (.clock(clock), .sys_rst(sys_rst), .sclk(serial_link_if_inst.sclk),
    .sdata(serial_link_if_inst.sdata), .le(serial_link_if_inst.le), .sdo(serial_link_if_inst.sdo));
  // ********************************************************************
  // clock, pulse monitors and hang guard
  // ********************************************************************
  initial forever #4 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (conversion_start === 1'b1) n_start++;
    if (req_refused === 1'b1) n_ref++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one request; ready is awaited both before and after so frames never overlap
  task automatic req(input logic rd, input logic [2:0] a, input logic [31:0] d);
    int n;
    // one idle edge first so valid never drops and rises in one time step
    @(negedge clock);
    n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin @(negedge clock); n++; end
    req_valid = 1; req_read = rd; req_addr = a; req_data = d;
    @(negedge clock);
    req_valid = 0;
    n = 0;
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(negedge clock);
      n++;
      if (rsp_valid === 1'b1) got = rsp_data;
    end
    chk("ready back", 32'h1, {31'h0, req_ready});
  endtask : req
  task automatic t_reset();
    req(1, 3'h3, 32'h0); chk("upper reset", 32'h00000043, got);
    req(1, 3'h4, 32'h0); chk("aux reset", 32'h00000004, got);
    chk("upper outs reset", 32'h008, {22'h0, uo});
    req(1, 3'h5, 32'h0); chk("unmapped read", 32'h0, got);
  endtask : t_reset
  task automatic t_upper();
    logic [31:0] e;
    for (int i = 0; i < 4; i++)
    begin
      pfd_fast = i[0];
      req(0, 3'h3, up_pat[i]);
      e = up_pat[i];
      chk("upper outs", {22'h0, e[13], |e[12:11], e[10:9], pfd_fast, e[7:3]}, {22'h0, uo});
      req(1, 3'h3, 32'h0);
      e = (e & 32'h0003fef8) | {23'h0, pfd_fast, 8'h03};
      chk("upper readback", e, got);
    end
    req(0, 3'h2, 32'hfffffff8); chk("write elsewhere", {22'h0, 10'h020}, {22'h0, uo});
  endtask : t_upper
  task automatic t_aux();
    logic [31:0] e;
    ax_last = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      e = ax_pat[i];
      req(0, 3'h4, e);
      if (e[18:7] == 12'h000) chk("zero divider refused", 32'h1, {31'h0, req_refused});
      else ax_last = e;
      chk("aux outs", {17'h0, ax_last[21:7]}, {17'h0, ao});
      chk("converter on", {31'h0, ax_last[6:4] == 3'h1}, {31'h0, converter_on});
      req(1, 3'h4, 32'h0);
      chk("aux readback", (ax_last & 32'h003ffff8) | 32'h4, got);
    end
    chk("no start off mode", 32'h0, n_start);
    chk("refusal count", 32'h1, n_ref);
  endtask : t_aux
  task automatic done_pulse(input logic [6:0] r);
    @(negedge clock);
    conv_done = 1; conv_result = r;
    @(negedge clock);
    conv_done = 0;
  endtask : done_pulse
  task automatic t_conv();
    req(1, 3'h6, 32'h0); chk("status first", 32'h80000806, got);
    req(0, 3'h4, 32'h00000098); chk("start count", 32'h1, n_start);
    chk("converter selected", 32'h1, {31'h0, converter_on});
    req(1, 3'h6, 32'h0); chk("status busy", 32'h80000006, got);
    done_pulse(7'h5a);
    req(1, 3'h6, 32'h0); chk("status valid", 32'h800006d6, got);
    done_pulse(7'h11);
    req(1, 3'h6, 32'h0); chk("status held", 32'h800006d6, got);
  endtask : t_conv
  initial
  begin
    repeat (5) @(negedge clock);
    sys_rst = 0;
    t_reset();
    t_upper();
    t_aux();
    t_conv();
    summarize();
  end
endmodule : tb
